// file: design/cpw_pkg.sv
package cpw_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [3:0] OFF_CMP0_CTRL = 4'h0;
   localparam logic [3:0] OFF_CMP1_CTRL = 4'h1;
   localparam logic [3:0] OFF_CMP0_MUX  = 4'h2;
   localparam logic [3:0] OFF_CMP1_MUX  = 4'h3;
   localparam logic [3:0] OFF_ROUTE     = 4'h4;
   localparam logic [3:0] OFF_SCALE     = 4'h5;
   localparam logic [3:0] OFF_WINDOW    = 4'h6;
   localparam logic [3:0] OFF_STATUS    = 4'h7;
   localparam logic [3:0] OFF_CURRENT   = 4'h8;
   localparam logic [3:0] OFF_TRIM      = 4'h9;

   // ----------------------------------------------------------------
   // Writable bits, reset value and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [7:0] MASK_MUX   = 8'h3F;
   localparam logic [7:0] MASK_ROUTE = 8'h03;
   localparam logic [7:0] MASK_SCALE = 8'h3F;
   localparam logic [7:0] MASK_WIN   = 8'h1F;
   localparam logic [7:0] MASK_CUR   = 8'hC3;
   localparam logic [7:0] MASK_TRIM  = 8'h0F;
   localparam int ROUTE_CMP0_BIT = 0;
   localparam int ROUTE_CMP1_BIT = 1;
   localparam int WIN_EN_BIT     = 4;
   localparam int CUR_EN_BIT     = 7;
   localparam int CUR_DBL_BIT    = 6;
   localparam int NUM_CMP        = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CPW_WIN_ABOVE   = 2'b00,
      CPW_WIN_INSIDE  = 2'b01,
      CPW_WIN_BELOW   = 2'b10,
      CPW_WIN_OUTSIDE = 2'b11
   } cpw_win_t;

   typedef enum logic [1:0] {
      CPW_EDGE_TOGGLE = 2'b00,
      CPW_EDGE_RSVD   = 2'b01,
      CPW_EDGE_FALL   = 2'b10,
      CPW_EDGE_RISE   = 2'b11
   } cpw_edge_t;

   typedef struct packed {
      cpw_edge_t  edge_condition;
      logic [1:0] irq_level;
      logic       high_speed;
      logic [1:0] hysteresis;
      logic       enable;
   } cpw_cmp_ctrl_t;

   typedef struct packed {
      logic [1:0] rsvd;
      logic [2:0] positive_input_select;
      logic [2:0] negative_input_select;
   } cpw_mux_t;

   typedef struct packed {
      logic       enable;
      logic       current_double;
      logic [3:0] rsvd;
      logic       cmp1_current_out;
      logic       cmp0_current_out;
   } cpw_cur_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } cpw_bus_req_t;

endpackage

// file: design/cpw_edge_det.sv
`timescale 1ns/10ps
`default_nettype none
module cpw_edge_det
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              level,
   input  wire logic              enable,
   input  wire cpw_pkg::cpw_edge_t cond,
   output logic                   evt_r
);

   logic prev_r;
   logic rise;
   logic fall;

   assign rise = level & ~prev_r;
   assign fall = ~level & prev_r;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         prev_r <= 1'b0;
      else
         prev_r <= level;
   end

   // Reserved condition never fires; event is independent of irq level
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         evt_r <= 1'b0;
      else if (!enable)
         evt_r <= 1'b0;
      else
      begin
         unique case (cond)
            cpw_pkg::CPW_EDGE_TOGGLE: evt_r <= rise | fall;
            cpw_pkg::CPW_EDGE_RSVD:   evt_r <= 1'b0;
            cpw_pkg::CPW_EDGE_FALL:   evt_r <= fall;
            cpw_pkg::CPW_EDGE_RISE:   evt_r <= rise;
         endcase
      end
   end

   property p_rise_evt;
      @(posedge clock) disable iff (!rst_n)
      (enable && cond == cpw_pkg::CPW_EDGE_RISE && level && !prev_r)
         |=> evt_r;
   endproperty
   a_rise_evt: assert property (p_rise_evt)
      else $error("rising edge gave no event");

   property p_fall_quiet;
      @(posedge clock) disable iff (!rst_n)
      (cond == cpw_pkg::CPW_EDGE_FALL && level) |=> !evt_r;
   endproperty
   a_fall_quiet: assert property (p_fall_quiet)
      else $error("falling mode fired on high level");

endmodule
`default_nettype wire

// file: design/cpw_window.sv
`timescale 1ns/10ps
`default_nettype none
module cpw_window
(
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              win_en,
   input  wire logic              upper_lvl,
   input  wire logic              lower_lvl,
   input  wire logic [1:0]        cond,
   output cpw_pkg::cpw_win_t      state_r,
   output logic                   evt_r
);

   cpw_pkg::cpw_win_t state_nxt;
   logic              match;
   logic              match_r;

   // Upper comparator high: signal above top; lower high: above bottom
   always_comb
   begin
      unique case ({upper_lvl, lower_lvl})
         2'b11:   state_nxt = cpw_pkg::CPW_WIN_ABOVE;
         2'b01:   state_nxt = cpw_pkg::CPW_WIN_INSIDE;
         2'b00:   state_nxt = cpw_pkg::CPW_WIN_BELOW;
         2'b10:   state_nxt = cpw_pkg::CPW_WIN_OUTSIDE;
      endcase
   end

   // Outside covers both above and below the range
   always_comb
   begin
      unique case (cond)
         2'b00:   match = state_nxt == cpw_pkg::CPW_WIN_ABOVE;
         2'b01:   match = state_nxt == cpw_pkg::CPW_WIN_INSIDE;
         2'b10:   match = state_nxt == cpw_pkg::CPW_WIN_BELOW;
         2'b11:   match = state_nxt != cpw_pkg::CPW_WIN_INSIDE;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         state_r <= cpw_pkg::CPW_WIN_ABOVE;
      else
         state_r <= state_nxt;
   end

   // Fires on entry into the chosen condition, not on every cycle in it
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         match_r <= 1'b0;
         evt_r   <= 1'b0;
      end
      else
      begin
         match_r <= win_en & match;
         evt_r   <= win_en & match & ~match_r;
      end
   end

   property p_win_inside;
      @(posedge clock) disable iff (!rst_n)
      (win_en && cond == 2'b01 && !upper_lvl && lower_lvl && !match_r)
         |=> evt_r;
   endproperty
   a_win_inside: assert property (p_win_inside)
      else $error("inside condition gave no window event");

endmodule
`default_nettype wire

// file: design/cpw_top.sv
// Behaviour
// - Route bit one drives comparator one to pin6
// - Route bit zero drives comparator zero to pin7
// - Six-bit factor sets scaler to Vcc(n+1)/64
// - Window control bit four enables window mode
// - Window condition: above, inside, below, outside
// - Nonzero window level enables and prioritises interrupt
// - Status bits 7:6 show live window state
// - Status bit five shows comparator one level
// - Status bit four shows comparator zero level
// - Window flag set on condition, cleared vector/write-one
// - Comparator one flag set on edge, cleared likewise
// - Comparator zero flag set on edge, cleared likewise
// - Current bit seven enables constant current source
// - Current bit six doubles each comparator's current
// - Current bit one drives current on cmp1 negative pin
// - Current bit zero drives current on cmp0 negative pin
// - Comparator output high when positive exceeds negative
// - Edge condition: toggle, falling, rising; 01 reserved
// - Events emitted regardless of interrupt enable
//
// The plain strobed port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module cpw_top
(
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire cpw_pkg::cpw_bus_req_t  bus,
   output logic [7:0]                  rdata_r,
   input  wire logic [1:0]             cmp_in,
   input  wire logic [2:0]             vec_ack,
   output logic                        pin6_out,
   output logic                        pin6_oe,
   output logic                        pin7_out,
   output logic                        pin7_oe,
   output logic [2:0]                  evt_out,
   output logic [2:0]                  irq_req,
   output logic [1:0]                  irq_level_win,
   output logic [1:0]                  irq_level_cmp1,
   output logic [1:0]                  irq_level_cmp0,
   output cpw_pkg::cpw_cmp_ctrl_t      cmp0_ctrl_r,
   output cpw_pkg::cpw_cmp_ctrl_t      cmp1_ctrl_r,
   output cpw_pkg::cpw_mux_t           cmp0_mux_r,
   output cpw_pkg::cpw_mux_t           cmp1_mux_r,
   output logic [5:0]                  supply_scale_factor,
   output cpw_pkg::cpw_cur_t           cur_r,
   output logic [3:0]                  current_trim
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]        route_r;
   logic [7:0]        scale_r;
   logic [7:0]        win_r;
   logic [7:0]        trim_r;
   logic [1:0]        lvl_r;
   logic [2:0]        flag_r;
   logic [2:0]        evt;
   logic [2:0]        w1c;
   logic [1:0]        win_state_rd;
   logic [7:0]        rd_nxt;
   logic [1:0]        cmp_en;
   cpw_pkg::cpw_edge_t cmp_cond [cpw_pkg::NUM_CMP];
   cpw_pkg::cpw_win_t win_state;
   logic              win_en;
   logic              wr_hit;

   assign win_en   = win_r[cpw_pkg::WIN_EN_BIT];
   assign wr_hit   = bus.wr;
   assign cmp_en   = {cmp1_ctrl_r.enable, cmp0_ctrl_r.enable};
   assign cmp_cond[0] = cmp0_ctrl_r.edge_condition;
   assign cmp_cond[1] = cmp1_ctrl_r.edge_condition;

   assign supply_scale_factor = scale_r[5:0];
   assign current_trim        = trim_r[3:0];
   assign irq_level_win       = win_r[1:0];
   assign irq_level_cmp1      = cmp1_ctrl_r.irq_level;
   assign irq_level_cmp0      = cmp0_ctrl_r.irq_level;
   assign pin6_oe             = route_r[cpw_pkg::ROUTE_CMP1_BIT];
   assign pin7_oe             = route_r[cpw_pkg::ROUTE_CMP0_BIT];

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Reserved bits are masked off so they always read back as zero
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cmp0_ctrl_r <= cpw_pkg::cpw_cmp_ctrl_t'(cpw_pkg::RST_BYTE);
         cmp1_ctrl_r <= cpw_pkg::cpw_cmp_ctrl_t'(cpw_pkg::RST_BYTE);
         cmp0_mux_r  <= cpw_pkg::cpw_mux_t'(cpw_pkg::RST_BYTE);
         cmp1_mux_r  <= cpw_pkg::cpw_mux_t'(cpw_pkg::RST_BYTE);
      end
      else if (wr_hit)
      begin
         if (bus.addr == cpw_pkg::OFF_CMP0_CTRL)
            cmp0_ctrl_r <= cpw_pkg::cpw_cmp_ctrl_t'(bus.wdata);
         if (bus.addr == cpw_pkg::OFF_CMP1_CTRL)
            cmp1_ctrl_r <= cpw_pkg::cpw_cmp_ctrl_t'(bus.wdata);
         if (bus.addr == cpw_pkg::OFF_CMP0_MUX)
            cmp0_mux_r <= cpw_pkg::cpw_mux_t'(bus.wdata & cpw_pkg::MASK_MUX);
         if (bus.addr == cpw_pkg::OFF_CMP1_MUX)
            cmp1_mux_r <= cpw_pkg::cpw_mux_t'(bus.wdata & cpw_pkg::MASK_MUX);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         route_r <= cpw_pkg::RST_BYTE;
         scale_r <= cpw_pkg::RST_BYTE;
         win_r   <= cpw_pkg::RST_BYTE;
         trim_r  <= cpw_pkg::RST_BYTE;
      end
      else if (wr_hit)
      begin
         if (bus.addr == cpw_pkg::OFF_ROUTE)
            route_r <= bus.wdata & cpw_pkg::MASK_ROUTE;
         if (bus.addr == cpw_pkg::OFF_SCALE)
            scale_r <= bus.wdata & cpw_pkg::MASK_SCALE;
         if (bus.addr == cpw_pkg::OFF_WINDOW)
            win_r <= bus.wdata & cpw_pkg::MASK_WIN;
         if (bus.addr == cpw_pkg::OFF_TRIM)
            trim_r <= bus.wdata & cpw_pkg::MASK_TRIM;
      end
   end

   // Current source enable, doubling and per-pin output enables
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cur_r <= cpw_pkg::cpw_cur_t'(cpw_pkg::RST_BYTE);
      else if (wr_hit && bus.addr == cpw_pkg::OFF_CURRENT)
         cur_r <= cpw_pkg::cpw_cur_t'(bus.wdata
                                      & cpw_pkg::MASK_CUR);
   end

   // ----------------------------------------------------------------
   // Comparator levels, events and window
   // ----------------------------------------------------------------
   // Analog outputs arrive already digital and synchronous
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         lvl_r <= 2'b00;
      else
         lvl_r <= cmp_in;
   end

   generate
      for (genvar i = 0; i < cpw_pkg::NUM_CMP; i++)
      begin : g_cmp
         cpw_edge_det u_edge
         (
            .clock  (clock),
            .rst_n  (rst_n),
            .level  (lvl_r[i]),
            .enable (cmp_en[i]),
            .cond   (cmp_cond[i]),
            .evt_r  (evt[i])
         );
      end
   endgenerate

   cpw_window u_window
   (
      .clock     (clock),
      .rst_n     (rst_n),
      .win_en    (win_en),
      .upper_lvl (lvl_r[0]),
      .lower_lvl (lvl_r[1]),
      .cond      (win_r[3:2]),
      .state_r   (win_state),
      .evt_r     (evt[2])
   );

   // ----------------------------------------------------------------
   // Flags: a set in the clearing cycle wins
   // ----------------------------------------------------------------
   assign w1c = (wr_hit && bus.addr == cpw_pkg::OFF_STATUS) ?
                bus.wdata[2:0] : 3'b000;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         flag_r <= 3'b000;
      else
         flag_r <= (flag_r & ~(w1c | vec_ack))
                   | evt;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         evt_out <= 3'b000;
         irq_req <= 3'b000;
      end
      else
      begin
         evt_out <= evt;
         irq_req <= flag_r & {|win_r[1:0], |cmp1_ctrl_r.irq_level,
                              |cmp0_ctrl_r.irq_level};
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pin6_out <= 1'b0;
         pin7_out <= 1'b0;
      end
      else
      begin
         pin6_out <= lvl_r[1];
         pin7_out <= lvl_r[0];
      end
   end

   // ----------------------------------------------------------------
   // Read data, valid in the cycle after the strobe only
   // ----------------------------------------------------------------
   assign win_state_rd = win_en ? win_state : 2'b00;

   always_comb
   begin
      unique case (bus.addr)
         cpw_pkg::OFF_CMP0_CTRL: rd_nxt = cmp0_ctrl_r;
         cpw_pkg::OFF_CMP1_CTRL: rd_nxt = cmp1_ctrl_r;
         cpw_pkg::OFF_CMP0_MUX:  rd_nxt = cmp0_mux_r;
         cpw_pkg::OFF_CMP1_MUX:  rd_nxt = cmp1_mux_r;
         cpw_pkg::OFF_ROUTE:     rd_nxt = route_r;
         cpw_pkg::OFF_SCALE:     rd_nxt = scale_r;
         cpw_pkg::OFF_WINDOW:    rd_nxt = win_r;
         cpw_pkg::OFF_STATUS:    rd_nxt = {win_state_rd, lvl_r[1], lvl_r[0],
                                           1'b0, flag_r};
         cpw_pkg::OFF_CURRENT:   rd_nxt = cur_r;
         cpw_pkg::OFF_TRIM:      rd_nxt = trim_r;
         default:                rd_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         rdata_r <= 8'h00;
      else if (bus.rd)
         rdata_r <= rd_nxt;
      else
         rdata_r <= 8'h00;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_route1;
      @(posedge clock) disable iff (!rst_n)
      (bus.wr && bus.addr == cpw_pkg::OFF_ROUTE)
         |=> pin6_oe == $past(bus.wdata[1]);
   endproperty
   a_route1: assert property (p_route1)
      else $error("pin6 enable does not follow route write");

   property p_pin7_level;
      @(posedge clock) disable iff (!rst_n)
      $past(rst_n, 2) |-> pin7_out == $past(cmp_in[0], 2);
   endproperty
   a_pin7_level: assert property (p_pin7_level)
      else $error("pin7 does not carry comparator zero");

   property p_reserved;
      @(posedge clock) disable iff (!rst_n)
      (bus.rd && bus.addr == cpw_pkg::OFF_CURRENT) |=> rdata_r[5:2] == 4'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved current bits read nonzero");

   property p_scale;
      @(posedge clock) disable iff (!rst_n)
      (bus.wr && bus.addr == cpw_pkg::OFF_SCALE)
         |=> supply_scale_factor == $past(bus.wdata[5:0]);
   endproperty
   a_scale: assert property (p_scale)
      else $error("scale factor not taken");

   property p_window_state;
      @(posedge clock) disable iff (!rst_n)
      (bus.rd && bus.addr == cpw_pkg::OFF_STATUS && !win_en)
         |=> rdata_r[7:6] == 2'b00;
   endproperty
   a_window_state: assert property (p_window_state)
      else $error("window state shown while window off");

   property p_levels;
      @(posedge clock) disable iff (!rst_n)
      ($past(rst_n, 2) && bus.rd && bus.addr == cpw_pkg::OFF_STATUS)
         |=> rdata_r[5:4] == $past(cmp_in, 2);
   endproperty
   a_levels: assert property (p_levels)
      else $error("status levels do not match comparators");

   property p_set_wins;
      @(posedge clock) disable iff (!rst_n)
      evt[2] |=> flag_r[2];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("window event lost");

   property p_clear;
      @(posedge clock) disable iff (!rst_n)
      (vec_ack[1] && !evt[1]) |=> !flag_r[1];
   endproperty
   a_clear: assert property (p_clear)
      else $error("comparator one flag not cleared by vector");

   property p_w1c;
      @(posedge clock) disable iff (!rst_n)
      (w1c[0] && !evt[0]) |=> !flag_r[0];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("comparator zero flag not cleared by write");

   property p_irq;
      @(posedge clock) disable iff (!rst_n)
      (flag_r[2] && win_r[1:0] == 2'b00) |=> !irq_req[2];
   endproperty
   a_irq: assert property (p_irq)
      else $error("window request with level zero");

   property p_current;
      @(posedge clock) disable iff (!rst_n)
      (bus.wr && bus.addr == cpw_pkg::OFF_CURRENT)
         |=> {cur_r.enable, cur_r.current_double, cur_r.cmp1_current_out,
              cur_r.cmp0_current_out} ==
             {$past(bus.wdata[7:6]), $past(bus.wdata[1:0])};
   endproperty
   a_current: assert property (p_current)
      else $error("current control not taken");

endmodule
`default_nettype wire

// file: tb/cpw_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cpw_top_tb;
   // ---------------------------------------------------------------
   // Bench signals and expectation tables
   // ---------------------------------------------------------------
   logic                   clock;
   logic                   rst_n;
   cpw_pkg::cpw_bus_req_t  bus;
   logic [7:0]             rdata_r;
   logic [1:0]             cmp_in;
   logic [2:0]             vec_ack;
   logic                   pin6_out, pin6_oe, pin7_out, pin7_oe;
   logic [2:0]             evt_out, irq_req;
   logic [1:0]             lvl_w, lvl_1, lvl_0;
   cpw_pkg::cpw_cmp_ctrl_t c0_ctrl, c1_ctrl;
   cpw_pkg::cpw_mux_t      m0, m1;
   logic [5:0]             scale;
   cpw_pkg::cpw_cur_t      cur;
   logic [3:0]             trim;
   int                     fails = 0;
   int                     compares = 0;
   int                     evt_cnt [3];
   // Writable bits per offset; status (7) is handled on its own
   logic [7:0] wmask [10] = '{8'hFF, 8'hFF, 8'h3F, 8'h3F, 8'h03,
                              8'h3F, 8'h1F, 8'h00, 8'hC3, 8'h0F};
   int         ecnt [4] = '{2, 0, 1, 1};
   logic [1:0] start [4] = '{2'b10, 2'b00, 2'b10, 2'b10};
   logic [1:0] tgt [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
   logic [7:0] wst [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};

   cpw_top cpw_top_inst
   (
      .clock               (clock),
      .rst_n               (rst_n),
      .bus                 (bus),
      .rdata_r             (rdata_r),
      .cmp_in              (cmp_in),
      .vec_ack             (vec_ack),
      .pin6_out            (pin6_out),
      .pin6_oe             (pin6_oe),
      .pin7_out            (pin7_out),
      .pin7_oe             (pin7_oe),
      .evt_out             (evt_out),
      .irq_req             (irq_req),
      .irq_level_win       (lvl_w),
      .irq_level_cmp1      (lvl_1),
      .irq_level_cmp0      (lvl_0),
      .cmp0_ctrl_r         (c0_ctrl),
      .cmp1_ctrl_r         (c1_ctrl),
      .cmp0_mux_r          (m0),
      .cmp1_mux_r          (m1),
      .supply_scale_factor (scale),
      .cur_r               (cur),
      .current_trim        (trim)
   );

   // ---------------------------------------------------------------
   // Clock, event counting, watchdog
   // ---------------------------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Counted on the sampling edge so one-cycle pulses are never missed
   always @(posedge clock)
      for (int i = 0; i < 3; i++)
         evt_cnt[i] += int'(evt_out[i]);

   initial
   begin
      #500000;
      fails++;
      stop_test();
   end

   // ---------------------------------------------------------------
   // Access and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected value at %0t: got %h want %h",
                  $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      @(posedge clock);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge clock);
      bus.rd <= 1'b0;
      #1;
      chk(rdata_r & m, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic set_cmp(input logic [1:0] v);
      @(posedge clock);
      cmp_in <= v;
   endtask

   task automatic stop_test();
      $display("fails=%0d compares=%0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      bus = '0;
      cmp_in = 2'b00;
      vec_ack = 3'b000;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      for (int a = 0; a < 10; a++)
         rd(a[3:0], 8'hFF, 8'h00);
      for (int a = 0; a < 10; a++)
         if (a != 7)
         begin
            wr(a[3:0], 8'hFF);
            rd(a[3:0], 8'hFF, wmask[a]);
         end
      cyc(1);
      chk({2'b00, scale}, 8'h3F);
      chk(cur, 8'hC3);
      chk({4'h0, trim}, 8'h0F);
      chk(m1, 8'h3F);
      chk(m0, 8'h3F);
      chk(c0_ctrl, 8'hFF);
      chk(c1_ctrl, 8'hFF);
      wr(4'hA, 8'hFF);
      rd(4'hA, 8'hFF, 8'h00);
      for (int a = 0; a < 10; a++)
         wr(a[3:0], 8'h00);
      wr(cpw_pkg::OFF_STATUS, 8'hFF);
      rd(cpw_pkg::OFF_STATUS, 8'hFF, 8'h00);
      // Pin routing and live levels
      wr(cpw_pkg::OFF_ROUTE, 8'h03);
      set_cmp(2'b10);
      cyc(4);
      chk({4'h0, pin6_oe, pin6_out, pin7_oe, pin7_out}, 8'h0E);
      rd(cpw_pkg::OFF_STATUS, 8'h30, 8'h20);
      set_cmp(2'b01);
      cyc(4);
      chk({4'h0, pin6_oe, pin6_out, pin7_oe, pin7_out}, 8'h0B);
      rd(cpw_pkg::OFF_STATUS, 8'h30, 8'h10);
      wr(cpw_pkg::OFF_ROUTE, 8'h02);
      cyc(1);
      chk({6'h00, pin6_oe, pin7_oe}, 8'h02);
      set_cmp(2'b00);
      cyc(4);
      // Edge conditions, interrupt level 0 first so events stand alone
      for (int n = 0; n < 2; n++)
         for (int e = 0; e < 4; e++)
         begin
            wr(n[3:0], {e[1:0], 2'b00, 4'h1});
            wr(cpw_pkg::OFF_STATUS, 8'h07);
            cyc(4);
            evt_cnt[n] = 0;
            set_cmp(2'(1 << n));
            cyc(5);
            set_cmp(2'b00);
            cyc(5);
            chk(8'(evt_cnt[n]), 8'(ecnt[e]));
            rd(cpw_pkg::OFF_STATUS, 8'(1 << n),
               ecnt[e] > 0 ? 8'(1 << n) : 8'h00);
            wr(n[3:0], {e[1:0], 2'b10, 4'h1});
            cyc(2);
            chk({7'h00, irq_req[n]}, ecnt[e] > 0 ? 8'h01 : 8'h00);
            chk({6'h00, n ? lvl_1 : lvl_0}, 8'h02);
            @(posedge clock);
            vec_ack <= 3'(1 << n);
            @(posedge clock);
            vec_ack <= 3'b000;
            cyc(2);
            chk({7'h00, irq_req[n]}, 8'h00);
            rd(cpw_pkg::OFF_STATUS, 8'(1 << n), 8'h00);
         end
      // Window off: no state shown, no window events
      evt_cnt[2] = 0;
      set_cmp(2'b11);
      cyc(4);
      rd(cpw_pkg::OFF_STATUS, 8'hC4, 8'h00);
      chk(8'(evt_cnt[2]), 8'h00);
      for (int c = 0; c < 4; c++)
      begin
         wr(cpw_pkg::OFF_WINDOW, 8'h00);
         set_cmp(start[c]);
         cyc(4);
         wr(cpw_pkg::OFF_WINDOW, {3'b000, 1'b1, c[1:0], 2'b01});
         cyc(4);
         wr(cpw_pkg::OFF_STATUS, 8'h04);
         cyc(1);
         evt_cnt[2] = 0;
         set_cmp(tgt[c]);
         cyc(5);
         chk(8'(evt_cnt[2]), 8'h01);
         chk({7'h00, irq_req[2]}, 8'h01);
         chk({6'h00, lvl_w}, 8'h01);
         rd(cpw_pkg::OFF_STATUS, 8'hC4, wst[c] | 8'h04);
         wr(cpw_pkg::OFF_STATUS, 8'h04);
         rd(cpw_pkg::OFF_STATUS, 8'h04, 8'h00);
      end
      stop_test();
   end
endmodule
`default_nettype wire
